/* File: verilog/cag_pkg.sv */
// cag_pkg: constants and types shared by the address generator and sequencer.
// assumes a 16-bit address space and an 8-bit data path.
package cag_pkg;
   localparam logic [15:0] CAG_RESET_VEC_HI = 16'hFFFE;
   localparam logic [15:0] CAG_RESET_VEC_LO = 16'hFFFF;
   localparam logic [7:0] CAG_DIRECT_PAGE = 8'h00;
   localparam logic [15:0] CAG_POST_INC = 16'h0001;
   localparam int CAG_MASK_BIT = 3;
   localparam logic [7:0] CAG_FLAGS_RST = 8'h08;
   localparam logic [15:0] CAG_SP_RST = 16'h00FF;
   localparam logic [15:0] CAG_TRAP_VEC = 16'hFFFC;
   localparam int CAG_RESET_CYCLES = 6;
   localparam int CAG_FILL_BYTES = 3;
   localparam int CAG_SRC_SYNC_CYCLES = 4;

   typedef enum logic [3:0]
   {
      CAG_AM_DIRECT = 4'h0,
      CAG_AM_EXTENDED = 4'h1,
      CAG_AM_IX = 4'h2,
      CAG_AM_IX_POST = 4'h3,
      CAG_AM_IX_BYTE = 4'h4,
      CAG_AM_IX_BYTE_POST = 4'h5,
      CAG_AM_IX_WORD = 4'h6,
      CAG_AM_SP_BYTE = 4'h7,
      CAG_AM_SP_WORD = 4'h8
   } cag_amode_t;

   typedef enum logic [2:0]
   {
      CAG_OP_NONE = 3'h0,
      CAG_OP_TRAP = 3'h1,
      CAG_OP_WAIT = 3'h2,
      CAG_OP_STOP = 3'h3,
      CAG_OP_HALT = 3'h4,
      CAG_OP_RTI = 3'h5,
      CAG_OP_CLEAR_MASK = 3'h6
   } cag_op_t;

   typedef enum logic [2:0]
   {
      CAG_DBG_NONE = 3'h0,
      CAG_DBG_ENTER = 3'h1,
      CAG_DBG_GO = 3'h2,
      CAG_DBG_STEP = 3'h3,
      CAG_DBG_TAGGED_RESUME_CMD = 3'h4
   } cag_dbg_cmd_t;
endpackage : cag_pkg

/* File: verilog/cag_ea_unit.sv */
// cag_ea_unit: effective address adder for all memory operand modes.
// assumes operand bytes and base registers are stable while amode is valid.
module cag_ea_unit
   import cag_pkg::*;
(
   // mode and operand bytes
   input wire cag_pkg::cag_amode_t amode,
   input wire logic [7:0] opnd_hi,
   input wire logic [7:0] opnd_lo,
   // base registers
   input wire logic [15:0] index_pair,
   input wire logic [15:0] stack_ptr,
   // results
   output logic [15:0] ea,
   output logic post_inc
);
   function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
      // sums wrap, no carry past bit 15
      add16 = 16'(a + b); // RL24
   endfunction

   always_comb
   begin
      post_inc = 1'b0;
      case (amode)
         CAG_AM_DIRECT: ea = {CAG_DIRECT_PAGE, opnd_lo}; // RL1
         CAG_AM_EXTENDED: ea = {opnd_hi, opnd_lo}; // RL2
         CAG_AM_IX: ea = index_pair; // RL3
         CAG_AM_IX_POST:
         begin
            ea = index_pair; // RL4
            post_inc = 1'b1;
         end
         CAG_AM_IX_BYTE: ea = add16(index_pair, {8'h00, opnd_lo}); // RL3
         CAG_AM_IX_BYTE_POST:
         begin
            ea = add16(index_pair, {8'h00, opnd_lo}); // RL5
            post_inc = 1'b1;
         end
         CAG_AM_IX_WORD: ea = add16(index_pair, {opnd_hi, opnd_lo}); // RL3
         CAG_AM_SP_BYTE: ea = add16(stack_ptr, {8'h00, opnd_lo}); // RL6
         CAG_AM_SP_WORD: ea = add16(stack_ptr, {opnd_hi, opnd_lo}); // RL6
         default: ea = index_pair;
      endcase
   end
endmodule // cag_ea_unit

/* File: verilog/cag_reset_ctl.sv */
// cag_reset_ctl: merges reset sources and decides when reset has ended.
// assumes the reset pin and watchdog inputs are synchronous to sys_clk.
module cag_reset_ctl
   import cag_pkg::*;
(
   // clock and power-on reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // other sources
   input wire logic watchdog_reset,
   input wire logic ext_reset_n,
   // status
   output logic in_reset,
   output logic reset_done
);
   logic [2:0] src_cnt_reg;
   logic pending_reg;

   // source determination runs for a fixed time after any event
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || watchdog_reset || !ext_reset_n) // RL7
      begin
         src_cnt_reg <= 3'(CAG_SRC_SYNC_CYCLES);
         pending_reg <= 1'b1;
      end
      else if (src_cnt_reg != 3'h0)
         src_cnt_reg <= 3'(src_cnt_reg - 3'h1);
      else
         pending_reg <= 1'b0;
   end

   // done only after determination and with the pin released
   assign in_reset = sys_rst || watchdog_reset || !ext_reset_n || pending_reg; // RL9
   assign reset_done = pending_reg && src_cnt_reg == 3'h0 && ext_reset_n && !watchdog_reset && !sys_rst; // RL9
endmodule // cag_reset_ctl

/* File: verilog/cag_sequencer.sv */
// cag_sequencer: operand address issue and special-operation sequencing.
// assumes decode supplies op/amode pulses at instruction boundaries and
// that memory returns read data the cycle after a read address.
// Functional notes
// RL1 - direct page: high byte zero
// RL2 - extended: two program bytes, high first
// RL3 - index pair, plus byte or word offset
// RL4 - index post-increment after fetch
// RL5 - byte offset plus index, then increment
// RL6 - stack pointer plus byte or word offset
// RL7 - reset from power-on, watchdog, pin
// RL8 - reset abandons activity immediately
// RL9 - reset ends after determination, pin released
// RL10 - six-cycle reset vector fetch and fill
// RL11 - interrupt waits for instruction end
// RL12 - vector of highest pending at start
// RL13 - push pc low, pc high, x, a, flags
// RL14 - set mask, vector hi, lo, idle, fill three
// RL15 - upper index byte never pushed
// RL16 - trap same sequence, ignores mask
// RL17 - wait clears mask, gates clocks
// RL18 - debug enter wakes wait into background
// RL19 - optional minimal clocks during stop
// RL20 - debug enable keeps oscillator, enter wakes stop
// RL21 - halt until reset or resume command
// RL22 - mask bit three blocks maskable interrupts
// RL23 - no interrupt right after mask clear
// RL24 - address sums wrap at sixteen bits
// RL25 - return pops flags, a, x, pc hi, pc lo
module cag_sequencer
   import cag_pkg::*;
#(
   parameter int NUM_IRQ = 8
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic watchdog_reset,
   input wire logic ext_reset_n,
   // decode side
   input wire logic instr_end,
   input wire cag_pkg::cag_op_t op_req,
   input wire cag_pkg::cag_amode_t amode,
   input wire logic operand_req,
   input wire logic [7:0] opnd_hi,
   input wire logic [7:0] opnd_lo,
   // cpu registers in
   input wire logic [15:0] index_pair,
   input wire logic [15:0] pc_next,
   input wire logic [7:0] accum,
   input wire logic [7:0] cond_flags_in,
   // interrupt sources, bit 0 highest priority
   input wire logic [NUM_IRQ-1:0] irq_pending,
   input wire logic [16*NUM_IRQ-1:0] irq_vectors,
   // debug and stop configuration
   input wire cag_pkg::cag_dbg_cmd_t dbg_cmd,
   input wire logic debug_enable_bit,
   input wire logic stop_keep_clocks,
   // memory bus
   input wire logic [7:0] mem_rdata,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_rd,
   output logic mem_wr,
   // state out
   output logic [15:0] index_out,
   output logic [15:0] stack_out,
   output logic [15:0] pc_out,
   output logic pc_load,
   output logic [7:0] cond_flags,
   output logic cpu_clk_en,
   output logic osc_keep,
   output logic background_active,
   output logic seq_busy
);
   typedef enum logic [3:0]
   {
      CAG_S_RESET = 4'h0,
      CAG_S_RVEC = 4'h1,
      CAG_S_RUN = 4'h2,
      CAG_S_PUSH = 4'h3,
      CAG_S_VECHI = 4'h4,
      CAG_S_VECLO = 4'h5,
      CAG_S_IDLE = 4'h6,
      CAG_S_FILL = 4'h7,
      CAG_S_WAIT = 4'h8,
      CAG_S_STOP = 4'h9,
      CAG_S_DEBUG_HALT_INSTR = 4'hA,
      CAG_S_POP = 4'hB
   } cag_state_t;

   cag_state_t state_reg;
   logic [2:0] step_reg;
   logic [15:0] vec_reg;
   logic [15:0] ret_pc_reg;
   logic [7:0] save_x_reg;
   logic [7:0] save_a_reg;
   logic [7:0] save_f_reg;
   logic [15:0] ea;
   logic post_inc;
   logic in_reset;
   logic reset_done;
   logic mask_shadow_reg;
   logic irq_take;
   logic [15:0] irq_vec;
   logic [15:0] index_reg;
   logic [15:0] sp_reg;
   logic [7:0] flags_reg;
   logic [15:0] addr_reg;
   logic [7:0] wdata_reg;
   logic rd_reg;
   logic wr_reg;
   logic [15:0] pc_reg;
   logic pc_load_reg;
   logic clk_en_reg;
   logic osc_reg;
   logic bg_reg;
   logic busy_reg;

   function automatic logic [15:0] pick_vector(input logic [NUM_IRQ-1:0] pend,
                                               input logic [16*NUM_IRQ-1:0] vecs);
      pick_vector = 16'h0000;
      for (int i = NUM_IRQ - 1; i >= 0; i--)
         if (pend[i])
            pick_vector = vecs[16*i +: 16]; // RL12
   endfunction

   cag_ea_unit u_ea
   (
      .amode(amode),
      .opnd_hi(opnd_hi),
      .opnd_lo(opnd_lo),
      .index_pair(index_reg),
      .stack_ptr(sp_reg),
      .ea(ea),
      .post_inc(post_inc)
   );

   cag_reset_ctl u_rst
   (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .watchdog_reset(watchdog_reset),
      .ext_reset_n(ext_reset_n),
      .in_reset(in_reset),
      .reset_done(reset_done)
   );

   // mask gating plus one-boundary holdoff after a mask clear
   assign irq_take = instr_end && (|irq_pending) && !flags_reg[CAG_MASK_BIT] && !mask_shadow_reg; // RL22 RL23
   assign irq_vec = pick_vector(irq_pending, irq_vectors);

   // main sequence; reset wins over everything at once
   always_ff @(posedge sys_clk)
   begin
      if (in_reset && !reset_done) // RL8
      begin
         state_reg <= CAG_S_RESET;
         step_reg <= 3'h0;
         vec_reg <= 16'h0000;
         ret_pc_reg <= 16'h0000;
         save_x_reg <= 8'h00;
         save_a_reg <= 8'h00;
         save_f_reg <= 8'h00;
      end
      else
      begin
         case (state_reg)
            CAG_S_RESET:
               if (reset_done)
               begin
                  state_reg <= CAG_S_RVEC; // RL10
                  step_reg <= 3'h0;
               end
            CAG_S_RVEC:
            begin
               step_reg <= 3'(step_reg + 3'h1);
               // read data trails its strobe by one cycle
               if (step_reg == 3'h2)
                  vec_reg[15:8] <= mem_rdata;
               if (step_reg == 3'h3)
                  vec_reg[7:0] <= mem_rdata;
               if (step_reg == 3'(CAG_RESET_CYCLES - 1))
                  state_reg <= CAG_S_RUN;
            end
            CAG_S_RUN:
               if (op_req == CAG_OP_TRAP || irq_take) // RL11 RL16
               begin
                  state_reg <= CAG_S_PUSH;
                  step_reg <= 3'h0;
                  vec_reg <= (op_req == CAG_OP_TRAP) ? CAG_TRAP_VEC : irq_vec; // RL12
                  ret_pc_reg <= pc_next; // RL11
                  save_x_reg <= index_reg[7:0]; // RL15
                  save_a_reg <= accum;
                  save_f_reg <= flags_reg;
               end
               else if (op_req == CAG_OP_RTI)
               begin
                  state_reg <= CAG_S_POP; // RL25
                  step_reg <= 3'h0;
               end
               else if (op_req == CAG_OP_WAIT)
                  state_reg <= CAG_S_WAIT; // RL17
               else if (op_req == CAG_OP_STOP)
                  state_reg <= CAG_S_STOP;
               else if (op_req == CAG_OP_HALT)
                  state_reg <= CAG_S_DEBUG_HALT_INSTR; // RL21
            CAG_S_PUSH:
            begin
               step_reg <= 3'(step_reg + 3'h1);
               if (step_reg == 3'h4)
                  state_reg <= CAG_S_VECHI; // RL13
            end
            CAG_S_VECHI: state_reg <= CAG_S_VECLO; // RL14
            CAG_S_VECLO: state_reg <= CAG_S_IDLE;
            CAG_S_IDLE:
            begin
               vec_reg[15:8] <= mem_rdata;
               state_reg <= CAG_S_FILL;
               step_reg <= 3'h0;
            end
            CAG_S_FILL:
            begin
               step_reg <= 3'(step_reg + 3'h1);
               if (step_reg == 3'h0)
                  vec_reg[7:0] <= mem_rdata;
               if (step_reg == 3'(CAG_FILL_BYTES - 1))
                  state_reg <= CAG_S_RUN; // RL14
            end
            CAG_S_POP:
            begin
               step_reg <= 3'(step_reg + 3'h1);
               // last popped byte lands two cycles after its read
               if (step_reg == 3'h6)
                  state_reg <= CAG_S_RUN;
            end
            CAG_S_WAIT:
               if (dbg_cmd == CAG_DBG_ENTER)
                  state_reg <= CAG_S_DEBUG_HALT_INSTR; // RL18
               else if (|irq_pending)
                  state_reg <= CAG_S_RUN; // RL17
            CAG_S_STOP:
               if (dbg_cmd == CAG_DBG_ENTER && debug_enable_bit)
                  state_reg <= CAG_S_DEBUG_HALT_INSTR; // RL20
               else if (stop_keep_clocks && (|irq_pending))
                  state_reg <= CAG_S_RUN; // RL19
            CAG_S_DEBUG_HALT_INSTR:
               if (dbg_cmd == CAG_DBG_GO || dbg_cmd == CAG_DBG_STEP || dbg_cmd == CAG_DBG_TAGGED_RESUME_CMD)
                  state_reg <= CAG_S_RUN; // RL21
            default: state_reg <= CAG_S_RESET;
         endcase
      end
   end

   // memory bus drive per state
   always_ff @(posedge sys_clk)
   begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
      if (in_reset)
         addr_reg <= 16'h0000;
      else
         case (state_reg)
            CAG_S_RVEC:
               if (step_reg == 3'h0 || step_reg == 3'h1)
               begin
                  addr_reg <= (step_reg == 3'h0) ? CAG_RESET_VEC_HI : CAG_RESET_VEC_LO; // RL10
                  rd_reg <= 1'b1;
               end
               else if (step_reg == 3'h3)
               begin
                  // low vector byte is on the bus now, not yet in vec_reg
                  addr_reg <= {vec_reg[15:8], mem_rdata}; // RL10
                  rd_reg <= 1'b1;
               end
               else if (step_reg > 3'h3)
               begin
                  addr_reg <= 16'(vec_reg + 16'(step_reg - 3'h3)); // RL10
                  rd_reg <= 1'b1;
               end
            CAG_S_RUN:
               if (operand_req)
               begin
                  addr_reg <= ea; // RL1 RL2 RL3 RL6
                  rd_reg <= 1'b1;
               end
            CAG_S_PUSH:
            begin
               addr_reg <= 16'(sp_reg);
               wr_reg <= 1'b1;
               case (step_reg)
                  3'h0: wdata_reg <= ret_pc_reg[7:0]; // RL13
                  3'h1: wdata_reg <= ret_pc_reg[15:8];
                  3'h2: wdata_reg <= save_x_reg;
                  3'h3: wdata_reg <= save_a_reg;
                  default: wdata_reg <= save_f_reg;
               endcase
            end
            CAG_S_VECHI:
            begin
               addr_reg <= vec_reg; // RL14
               rd_reg <= 1'b1;
            end
            CAG_S_VECLO:
            begin
               addr_reg <= 16'(vec_reg + 16'h0001);
               rd_reg <= 1'b1;
            end
            CAG_S_FILL:
            begin
               if (step_reg == 3'h0)
                  addr_reg <= {vec_reg[15:8], mem_rdata}; // RL14
               else
                  addr_reg <= 16'(vec_reg + 16'(step_reg)); // RL14
               rd_reg <= 1'b1;
            end
            CAG_S_POP:
               if (step_reg < 3'h5)
               begin
                  addr_reg <= 16'(sp_reg + 16'h0001); // RL25
                  rd_reg <= 1'b1;
               end
            default: addr_reg <= addr_reg;
         endcase
   end

   // stack pointer: push decrements, pop pre-increments, wraps
   always_ff @(posedge sys_clk)
   begin
      if (in_reset)
         sp_reg <= CAG_SP_RST;
      else if (state_reg == CAG_S_PUSH)
         sp_reg <= 16'(sp_reg - 16'h0001); // RL24
      else if (state_reg == CAG_S_POP && step_reg < 3'h5)
         sp_reg <= 16'(sp_reg + 16'h0001); // RL24
   end

   // index pair: load from core, post-increment after operand fetch
   always_ff @(posedge sys_clk)
   begin
      if (in_reset)
         index_reg <= 16'h0000;
      else if (state_reg == CAG_S_RUN && operand_req && post_inc)
         index_reg <= 16'(index_pair + CAG_POST_INC); // RL4 RL5 RL24
      else if (state_reg == CAG_S_POP && step_reg == 3'h4)
         index_reg <= {index_pair[15:8], mem_rdata}; // RL15
      else if (state_reg == CAG_S_RUN)
         index_reg <= index_pair;
   end

   // condition flags, mask bit and post-clear holdoff
   always_ff @(posedge sys_clk)
   begin
      if (in_reset)
      begin
         flags_reg <= CAG_FLAGS_RST;
         mask_shadow_reg <= 1'b0;
      end
      else
      begin
         if (instr_end)
            mask_shadow_reg <= (op_req == CAG_OP_CLEAR_MASK); // RL23
         if (state_reg == CAG_S_VECHI)
            flags_reg[CAG_MASK_BIT] <= 1'b1; // RL14
         else if (state_reg == CAG_S_RUN && op_req == CAG_OP_WAIT)
            flags_reg[CAG_MASK_BIT] <= 1'b0; // RL17
         else if (state_reg == CAG_S_POP && step_reg == 3'h2)
            flags_reg <= mem_rdata; // RL25
         else if (state_reg == CAG_S_RUN)
            flags_reg <= cond_flags_in;
      end
   end

   // pc reload from popped bytes or fetched vector
   always_ff @(posedge sys_clk)
   begin
      pc_load_reg <= 1'b0;
      if (in_reset)
         pc_reg <= 16'h0000;
      else if (state_reg == CAG_S_POP && step_reg == 3'h5)
         pc_reg[15:8] <= mem_rdata;
      else if (state_reg == CAG_S_POP && step_reg == 3'h6)
      begin
         pc_reg[7:0] <= mem_rdata; // RL25
         pc_load_reg <= 1'b1;
      end
      else if ((state_reg == CAG_S_FILL && step_reg == 3'h1) || (state_reg == CAG_S_RVEC && step_reg == 3'h4))
      begin
         pc_reg <= vec_reg;
         pc_load_reg <= 1'b1;
      end
   end

   // clock gating and background status
   always_ff @(posedge sys_clk)
   begin
      if (in_reset)
      begin
         clk_en_reg <= 1'b1;
         osc_reg <= 1'b1;
         bg_reg <= 1'b0;
         busy_reg <= 1'b1;
      end
      else
      begin
         clk_en_reg <= !(state_reg == CAG_S_WAIT || state_reg == CAG_S_STOP); // RL17
         // oscillator survives stop only when debug or keep-alive asks
         osc_reg <= (state_reg != CAG_S_STOP) || debug_enable_bit || stop_keep_clocks; // RL19 RL20
         bg_reg <= (state_reg == CAG_S_DEBUG_HALT_INSTR); // RL21
         busy_reg <= (state_reg != CAG_S_RUN);
      end
   end

   assign mem_addr = addr_reg;
   assign mem_wdata = wdata_reg;
   assign mem_rd = rd_reg;
   assign mem_wr = wr_reg;
   assign index_out = index_reg;
   assign stack_out = sp_reg;
   assign pc_out = pc_reg;
   assign pc_load = pc_load_reg;
   assign cond_flags = flags_reg;
   assign cpu_clk_en = clk_en_reg;
   assign osc_keep = osc_reg;
   assign background_active = bg_reg;
   assign seq_busy = busy_reg;

   sequence s_push_start;
      state_reg == CAG_S_RUN && !in_reset && irq_take && op_req == CAG_OP_NONE;
   endsequence
   sequence s_vec_issue;
      (state_reg == CAG_S_PUSH) ##5 (state_reg == CAG_S_VECHI);
   endsequence

   chk_irq_entry_push: assert property (@(posedge sys_clk) disable iff (in_reset) // RL13
      s_push_start |=> s_vec_issue)
      else $error("interrupt push sequence wrong length");
   chk_push_writes: assert property (@(posedge sys_clk) disable iff (in_reset) // RL13
      state_reg == CAG_S_PUSH |=> mem_wr)
      else $error("push cycle did not write");
   chk_mask_set: assert property (@(posedge sys_clk) disable iff (in_reset) // RL14
      state_reg == CAG_S_VECHI |=> flags_reg[CAG_MASK_BIT])
      else $error("mask not set after stacking");
   chk_mask_blocks: assert property (@(posedge sys_clk) disable iff (in_reset) // RL22
      state_reg == CAG_S_RUN && flags_reg[CAG_MASK_BIT] && op_req != CAG_OP_TRAP |=> state_reg != CAG_S_PUSH)
      else $error("interrupt taken while masked");
   chk_wait_gates: assert property (@(posedge sys_clk) disable iff (in_reset) // RL17
      state_reg == CAG_S_RUN && op_req == CAG_OP_WAIT && !irq_take |=> ##1 !cpu_clk_en)
      else $error("wait did not gate clocks");
   chk_debug_halt_instr_hold: assert property (@(posedge sys_clk) disable iff (in_reset) // RL21
      state_reg == CAG_S_DEBUG_HALT_INSTR && dbg_cmd == CAG_DBG_NONE |=> state_reg == CAG_S_DEBUG_HALT_INSTR)
      else $error("left background without command");
   chk_post_inc: assert property (@(posedge sys_clk) disable iff (in_reset) // RL4
      state_reg == CAG_S_RUN && operand_req && post_inc |=> index_reg == 16'($past(index_pair) + 16'h0001))
      else $error("index not incremented");
   chk_reset_vec: assert property (@(posedge sys_clk) disable iff (in_reset && !reset_done) // RL10
      state_reg == CAG_S_RESET && reset_done |=> ##1 (mem_addr == CAG_RESET_VEC_HI && mem_rd))
      else $error("reset vector fetch missing");
endmodule // cag_sequencer

/* File: verif/cag_mem_model.sv */
// cag_mem_model: byte memory on the far side of the sequencer bus.
// assumes read data is due the cycle after a read strobe.
module cag_mem_model
(
   // clock
   input wire logic sys_clk,
   // bus
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial mem_rdata = 8'h00;
   // off-cycle data inverts, so a stale byte never passes
   always @(posedge sys_clk)
   begin
      if (mem_rd === 1'b1)
         mem_rdata <= mem_addr[7:0] + 8'h11;
      else
         mem_rdata <= ~mem_rdata;
   end
endmodule // cag_mem_model

/* File: verif/cag_sequencer_tb.sv */
// cag_sequencer_tb: self-checking bench for the sequencer.
// assumes memory holds address low byte plus 11 hex.
module cag_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cag_pkg::*;
   logic sys_clk = 1'b0, sys_rst = 1'b1, watchdog_reset = 1'b0, ext_reset_n = 1'b0;
   logic instr_end = 1'b0, operand_req = 1'b0, debug_enable_bit = 1'b1, stop_keep_clocks = 1'b0;
   cag_op_t op_req = CAG_OP_NONE;
   cag_amode_t amode = CAG_AM_DIRECT;
   cag_dbg_cmd_t dbg_cmd = CAG_DBG_NONE;
   logic [7:0] opnd_hi = 8'h12, opnd_lo = 8'h34, accum = 8'hA5, cond_flags_in = 8'h08;
   logic [15:0] index_pair = 16'hFFFF, pc_next = 16'h0000;
   logic [7:0] irq_pending = 8'h00;
   logic [127:0] irq_vectors;
   wire [7:0] mem_rdata, mem_wdata, cond_flags;
   wire [15:0] mem_addr, index_out, stack_out, pc_out;
   wire mem_rd, mem_wr, pc_load, cpu_clk_en, osc_keep, background_active, seq_busy;
   int miscompares = 0, checked = 0;
   logic [15:0] rq[$];
   logic [23:0] wq[$];
   logic [15:0] ea_exp[9] = '{16'h0034, 16'h1234, 16'hFFFF, 16'hFFFF, 16'h0033,
      16'h0033, 16'h1233, 16'h0133, 16'h1333};

   always #12.5 sys_clk = ~sys_clk;
   cag_sequencer dut (.*);
   cag_mem_model mem (.*);

   always @(posedge sys_clk)
   begin
      if (mem_rd === 1'b1)
         rq.push_back(mem_addr);
      if (mem_wr === 1'b1)
         wq.push_back({mem_addr, mem_wdata});
   end

   // core side: takes flags back on a pc reload, clears mask on request
   always @(posedge sys_clk)
   begin
      if (pc_load === 1'b1)
         cond_flags_in <= cond_flags;
      else if (instr_end && op_req == CAG_OP_CLEAR_MASK)
         cond_flags_in <= cond_flags_in & 8'hF7;
   end

   task automatic tally_and_finish;
      if (miscompares == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // 0 busy, 1 clock enable, 2 background
   task automatic wait_for(input int w, input logic v);
      logic s;
      for (int i = 0; i < 100; i++)
      begin
         @(posedge sys_clk);
         s = (w == 0) ? seq_busy : (w == 1) ? cpu_clk_en : background_active;
         if (s === v)
            return;
      end
      miscompares++;
      tally_and_finish;
   endtask

   task automatic boundary(input cag_op_t op);
      @(posedge sys_clk);
      instr_end <= 1'b1;
      op_req <= op;
      @(posedge sys_clk);
      instr_end <= 1'b0;
      op_req <= CAG_OP_NONE;
   endtask

   task automatic dbg(input cag_dbg_cmd_t c);
      @(posedge sys_clk);
      dbg_cmd <= c;
      @(posedge sys_clk);
      dbg_cmd <= CAG_DBG_NONE;
   endtask

   task automatic chk_vec(input logic [15:0] v);
      logic [15:0] t;
      t = {v[7:0] + 8'h11, v[7:0] + 8'h12};
      chk(24'(rq.size()), 24'd5);
      chk(rq[0], v);
      chk(rq[1], v + 16'h0001);
      for (int i = 0; i < 3; i++)
         chk(rq[2 + i], t + 16'(i));
      chk(pc_out, t);
      rq.delete();
   endtask

   task automatic entry(input logic [15:0] sp, input logic [15:0] v, input logic [15:0] pc);
      chk(24'(wq.size()), 24'd5);
      chk(wq[0], {sp, pc[7:0]});
      chk(wq[1], {sp - 16'd1, pc[15:8]});
      chk(wq[2], {sp - 16'd2, index_pair[7:0]});
      chk(wq[3], {sp - 16'd3, accum});
      chk(wq[4][23:8], sp - 16'd4);
      chk(cond_flags[3], 1'b1);
      chk(stack_out, sp - 16'd5);
      chk_vec(v);
      wq.delete();
   endtask

   task automatic sc_reset;
      tick(6);
      sys_rst <= 1'b0;
      tick(8);
      chk(24'(rq.size()), 24'd0);
      ext_reset_n <= 1'b1;
      tick(2);
      wait_for(0, 1'b0);
      chk(stack_out, CAG_SP_RST);
      chk(cond_flags, CAG_FLAGS_RST);
      chk_vec(16'hFFFE);
   endtask

   task automatic sc_addr;
      for (int m = 0; m < 9; m++)
      begin
         @(posedge sys_clk);
         amode <= cag_amode_t'(m);
         operand_req <= 1'b1;
         @(posedge sys_clk);
         operand_req <= 1'b0;
         @(posedge sys_clk);
         if (m == 3 || m == 5)
            chk(index_out, 16'h0000);
         for (int k = 0; k < 10 && rq.size() == 0; k++)
            @(posedge sys_clk);
         chk(rq[0], ea_exp[m]);
         rq.delete();
      end
   endtask

   task automatic sc_irq;
      pc_next <= 16'h1234;
      boundary(CAG_OP_CLEAR_MASK);
      irq_pending <= 8'h06;
      boundary(CAG_OP_NONE);
      tick(8);
      chk(24'(wq.size()), 24'd0);
      boundary(CAG_OP_NONE);
      tick(3);
      wait_for(0, 1'b0);
      irq_pending <= 8'h00;
      entry(16'h00FF, 16'hFFEE, 16'h1234);
   endtask

   task automatic sc_trap;
      irq_pending <= 8'h01;
      pc_next <= 16'h5678;
      boundary(CAG_OP_NONE);
      tick(8);
      chk(24'(wq.size()), 24'd0);
      boundary(CAG_OP_TRAP);
      irq_pending <= 8'h00;
      tick(3);
      wait_for(0, 1'b0);
      entry(16'h00FA, CAG_TRAP_VEC, 16'h5678);
      boundary(CAG_OP_RTI);
      for (int k = 0; k < 20 && rq.size() < 5; k++)
         @(posedge sys_clk);
      for (int i = 0; i < 5; i++)
         chk(rq[i], 16'h00F6 + 16'(i));
      wait_for(0, 1'b0);
      chk(pc_out, 16'h0A0B);
      rq.delete();
   endtask

   task automatic sc_sleep;
      for (int k = 0; k < 2; k++)
      begin
         boundary(k ? CAG_OP_STOP : CAG_OP_WAIT);
         wait_for(1, 1'b0);
         if (k == 0)
            chk(cond_flags[3], 1'b0);
         else
            chk(osc_keep, 1'b1);
         dbg(CAG_DBG_ENTER);
         wait_for(2, 1'b1);
         chk(cpu_clk_en, 1'b1);
         dbg(CAG_DBG_GO);
         wait_for(2, 1'b0);
      end
      boundary(CAG_OP_WAIT);
      wait_for(1, 1'b0);
      irq_pending <= 8'h01;
      wait_for(1, 1'b1);
      irq_pending <= 8'h00;
      for (int k = 2; k < 5; k++)
      begin
         boundary(CAG_OP_HALT);
         wait_for(2, 1'b1);
         dbg(cag_dbg_cmd_t'(k));
         wait_for(2, 1'b0);
      end
   endtask

   task automatic sc_wdog;
      boundary(CAG_OP_TRAP);
      tick(2);
      watchdog_reset <= 1'b1;
      tick(2);
      watchdog_reset <= 1'b0;
      wq.delete();
      rq.delete();
      tick(2);
      wait_for(0, 1'b0);
      chk(24'(wq.size()), 24'd0);
      chk_vec(16'hFFFE);
   endtask

   initial
   begin
      for (int i = 0; i < 8; i++)
         irq_vectors[16 * i +: 16] = 16'hFFF0 - 16'(2 * i);
      sc_reset;
      sc_addr;
      sc_irq;
      sc_trap;
      sc_sleep;
      sc_wdog;
      tally_and_finish;
   end
endmodule // cag_sequencer_tb
